// File: rtl/pioc_clocking.sv
`timescale 1ns/10ps
`default_nettype none
`include "pioc_defines.svh"
// Overview of operation
// - pll runs only in the four pll-based oscillator modes
// - pll multiplies its fixed reference by twenty-four for usb and core
// - eight prescaler settings up to twelve bring the input to the reference
// - core from pll is pll output divided by two, three, four or six
// - fast and external pll modes accept inputs up to 48 MHz
// - slow crystal pll mode feeds the input to the pll undivided
// - fast internal oscillator gives 8 MHz and feeds a postscaler
// - fast oscillator enabled when 125 kHz to 8 MHz is selected
// - slow rc runs when selected or any timer-type feature is on
// - internal frequency select picks fast direct, slow rc, or postscaler
// - internal core modes take usb from one of four primary modes
// - trim value moves the fast oscillator in uniform steps
// - new trim takes effect after settling time, with no status flag
// - low-frequency source bit picks fast/256 or slow rc for 31 kHz
// - trim is signed: zero centre, 01111 max, 10000 min
// - trim bits six and five read as zero
// - trim changes never affect the slow rc frequency
// - usb needs 6 MHz low speed or 48 MHz full speed
// - low-speed usb clock is primary core chain divided by four
// - non-pll modes divide the core by one, two, three or four
module pioc_clocking
  import pioc_pkg::*;
#(
  parameter int        SETTLE_CYCLES = `PIOC_SETTLE_CYC,
  parameter pioc_khz_t TRIM_STEP_KHZ = 24'd40,
  parameter pioc_khz_t SLOW_KHZ      = 24'd31,
  parameter pioc_khz_t SEC_KHZ       = 24'd32
) (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  // axi4-lite write channels
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  // axi4-lite read channels
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  // primary oscillator input frequency
  input  wire pioc_khz_t   OSC_KHZ_I,
  // clock network results
  output pioc_freq_t       FREQ_O,
  output pioc_en_t         EN_O,
  output pioc_osc2_t       OSC2_FUNC_O,
  output logic [4:0]       TRIM_APPLIED_O
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]  internal_osc_trim;
  logic [31:0] clock_config;
  logic [31:0] osc_control_reg;
  logic [31:0] feature_enable;
  logic [31:0] status;
  logic [4:0]  trim_applied;
  logic        settle_done;
  logic        trim_write;
  // ----------------------------------------
  // axi write path
  // ----------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        wr_hit;

  assign S_AXI_AWREADY_O = !aw_held && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O  = !w_held && !S_AXI_BVALID_O;
  assign do_write        = aw_held && w_held && !S_AXI_BVALID_O;
  assign wr_hit = (aw_addr == `PIOC_OFS_TRIM) || (aw_addr == `PIOC_OFS_CFG) ||
                  (aw_addr == `PIOC_OFS_CTRL) || (aw_addr == `PIOC_OFS_FEAT) ||
                  (aw_addr == `PIOC_OFS_STAT) || (aw_addr == `PIOC_OFS_CORE) ||
                  (aw_addr == `PIOC_OFS_USB);
  assign trim_write = do_write && (aw_addr == `PIOC_OFS_TRIM) && w_strb[0];

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_held <= 1'b1;
      aw_addr <= {S_AXI_AWADDR_I[7:2], 2'b00};
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA_I;
      w_strb <= S_AXI_WSTRB_I;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= 2'b00;
    end else if (do_write) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O  <= wr_hit ? 2'b00 : 2'b11;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st, input logic [31:0] msk);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res & msk;
  endfunction

  // unused trim bits are masked so they always read zero
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      internal_osc_trim <= `PIOC_RST_TRIM;
    end else if (trim_write) begin
      internal_osc_trim <= w_data[7:0] & `PIOC_TRIM_MASK;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      clock_config <= `PIOC_RST_CFG;
    end else if (do_write && aw_addr == `PIOC_OFS_CFG) begin
      clock_config <= merge(clock_config, w_data, w_strb, `PIOC_CFG_MASK);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      osc_control_reg <= `PIOC_RST_CTRL;
    end else if (do_write && aw_addr == `PIOC_OFS_CTRL) begin
      osc_control_reg <= merge(osc_control_reg, w_data, w_strb, `PIOC_CTRL_MASK);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      feature_enable <= `PIOC_RST_FEAT;
    end else if (do_write && aw_addr == `PIOC_OFS_FEAT) begin
      feature_enable <= merge(feature_enable, w_data, w_strb, `PIOC_FEAT_MASK);
    end
  end

  // ----------------------------------------
  // trim settling
  // ----------------------------------------
  // two register stages follow the timer, so it counts that much less
  pioc_settle_timer #(
    .CYCLES (SETTLE_CYCLES - 2)
  ) u_settle (
    .clk_i   (CLK_I),
    .srst_i  (SRST_I),
    .start_i (trim_write),
    .done_o  (settle_done)
  );

  // oscillator drifts to the new value; software sees no completion flag
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      trim_applied <= 5'h00;
    end else if (settle_done) begin
      trim_applied <= internal_osc_trim[4:0];
    end
  end

  // ----------------------------------------
  // frequency plan
  // ----------------------------------------
  pioc_mode_t        mode;
  logic [2:0]        ifs;
  logic              pll_mode;
  logic              int_mode;
  logic              fast_pll_mode;
  logic signed [24:0] fast_s;
  pioc_khz_t         fast_khz;
  pioc_khz_t         low_khz;
  pioc_khz_t         pll_ref;
  pioc_khz_t         primary_core;
  pioc_freq_t        next_freq;
  pioc_en_t          next_en;
  pioc_osc2_t        next_osc2;
  logic [31:0]       next_status;

  function automatic pioc_khz_t prescale(input pioc_khz_t f, input logic [2:0] s);
    unique case (s)
      3'h0: return f;
      3'h1: return f / 24'd2;
      3'h2: return f / 24'd3;
      3'h3: return f / 24'd4;
      3'h4: return f / 24'd5;
      3'h5: return f / 24'd6;
      3'h6: return f / 24'd10;
      3'h7: return f / 24'd12;
    endcase
  endfunction

  always_comb begin
    mode     = pioc_mode_t'(clock_config[`PIOC_CFG_MODE]);
    ifs      = osc_control_reg[`PIOC_CTRL_IFS];
    int_mode = clock_config[3];
    pll_mode = (mode == fast_crystal_pll_mode) || (mode == slow_crystal_pll_mode) ||
               (mode == ext_clock_pll_mode) || (mode == ext_clock_pll_gpio_mode);
    fast_pll_mode = pll_mode && (mode != slow_crystal_pll_mode);
    // signed trim, uniform steps; slow rc has no trim input
    fast_s = $signed(25'(`PIOC_FAST_KHZ)) +
             $signed({{20{trim_applied[4]}}, trim_applied}) *
             $signed(25'(TRIM_STEP_KHZ));
    fast_khz = fast_s[23:0];
    low_khz = internal_osc_trim[`PIOC_TRIM_SRC] ? (fast_khz >> 8) : SLOW_KHZ;
    next_freq.fast = fast_khz;
    unique case (ifs)
      3'h0:    next_freq.internal = low_khz;
      3'h7:    next_freq.internal = fast_khz;
      default: next_freq.internal = fast_khz >> (3'h7 - ifs);
    endcase
    pll_ref = (mode == slow_crystal_pll_mode) ? OSC_KHZ_I
                                              : prescale(OSC_KHZ_I, clock_config[`PIOC_CFG_PRE]);
    next_freq.pll_out = pll_mode ? 24'(pll_ref * `PIOC_PLL_MULT) : 24'h000000;
    if (pll_mode) begin
      unique case (clock_config[`PIOC_CFG_CDIV])
        2'h0: primary_core = next_freq.pll_out / 24'd2;
        2'h1: primary_core = next_freq.pll_out / 24'd3;
        2'h2: primary_core = next_freq.pll_out / 24'd4;
        2'h3: primary_core = next_freq.pll_out / 24'd6;
      endcase
    end else begin
      unique case (clock_config[`PIOC_CFG_CDIV])
        2'h0: primary_core = OSC_KHZ_I;
        2'h1: primary_core = OSC_KHZ_I / 24'd2;
        2'h2: primary_core = OSC_KHZ_I / 24'd3;
        2'h3: primary_core = OSC_KHZ_I / 24'd4;
      endcase
    end
    if (int_mode || osc_control_reg[1]) begin
      next_freq.core = next_freq.internal;
    end else if (osc_control_reg[0]) begin
      next_freq.core = SEC_KHZ;
    end else begin
      next_freq.core = primary_core;
    end
    if (!clock_config[`PIOC_CFG_USBEN]) begin
      next_freq.usb = 24'h000000;
    end else if (clock_config[`PIOC_CFG_USBLS]) begin
      next_freq.usb = primary_core / `PIOC_LS_USB_DIV;
    end else begin
      next_freq.usb = pll_mode ? next_freq.pll_out / 24'd2 : OSC_KHZ_I;
    end
    next_en.pll  = pll_mode;
    next_en.fast = (ifs != 3'h0) || internal_osc_trim[`PIOC_TRIM_SRC];
    next_en.slow = ((int_mode || osc_control_reg[1]) && ifs == 3'h0 &&
                    !internal_osc_trim[`PIOC_TRIM_SRC]) ||
                   (feature_enable[3:0] != 4'h0);
    next_en.xtal_hs = (mode == fast_crystal_mode) || (mode == fast_crystal_pll_mode) ||
                      (mode == internal_core_fast_crystal_usb) || fast_pll_mode;
    next_en.xtal_lp = (mode == slow_crystal_mode) || (mode == slow_crystal_pll_mode) ||
                      (mode == internal_core_slow_crystal_usb);
    unique case (mode)
      ext_clock_mode, ext_clock_pll_mode, internal_core_ext_clock_out_usb:
        next_osc2 = osc2_quarter;
      ext_clock_gpio_mode, ext_clock_pll_gpio_mode, internal_core_ext_clock_gpio_usb:
        next_osc2 = osc2_gpio;
      default:
        next_osc2 = osc2_crystal;
    endcase
    next_status = 32'h0000_0000;
    next_status[0] = next_en.pll;
    next_status[1] = next_en.fast;
    next_status[2] = next_en.slow;
    next_status[3] = !pll_mode || (pll_ref == `PIOC_PLL_REF_KHZ);
    next_status[4] = !clock_config[`PIOC_CFG_USBEN] ||
                     (next_freq.usb == (clock_config[`PIOC_CFG_USBLS] ? `PIOC_LS_USB_KHZ
                                                                       : `PIOC_FS_USB_KHZ));
    // the core limit is the configuring party's duty; it is only reported
    next_status[5] = clock_config[`PIOC_CFG_USBEN] && clock_config[`PIOC_CFG_USBLS] &&
                     !int_mode && (osc_control_reg[1:0] == 2'b00) &&
                     (primary_core != `PIOC_LS_CORE_KHZ);
    next_status[6] = !fast_pll_mode || (OSC_KHZ_I <= `PIOC_MAX_OSC_KHZ);
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      FREQ_O         <= '0;
      EN_O           <= '0;
      OSC2_FUNC_O    <= osc2_crystal;
      status         <= 32'h0000_0000;
      TRIM_APPLIED_O <= 5'h00;
    end else begin
      FREQ_O         <= next_freq;
      EN_O           <= next_en;
      OSC2_FUNC_O    <= next_osc2;
      status         <= next_status;
      TRIM_APPLIED_O <= trim_applied;
    end
  end

  // ----------------------------------------
  // axi read path
  // ----------------------------------------
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= 32'h0000_0000;
      S_AXI_RRESP_O  <= 2'b00;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RRESP_O  <= 2'b00;
      unique case ({S_AXI_ARADDR_I[7:2], 2'b00})
        `PIOC_OFS_TRIM: S_AXI_RDATA_O <= {24'h000000, internal_osc_trim};
        `PIOC_OFS_CFG:  S_AXI_RDATA_O <= clock_config;
        `PIOC_OFS_CTRL: S_AXI_RDATA_O <= osc_control_reg;
        `PIOC_OFS_FEAT: S_AXI_RDATA_O <= feature_enable;
        `PIOC_OFS_STAT: S_AXI_RDATA_O <= status;
        `PIOC_OFS_CORE: S_AXI_RDATA_O <= {8'h00, FREQ_O.core};
        `PIOC_OFS_USB:  S_AXI_RDATA_O <= {8'h00, FREQ_O.usb};
        default: begin
          S_AXI_RDATA_O <= 32'h0000_0000;
          S_AXI_RRESP_O <= 2'b11;
        end
      endcase
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: rtl/pioc_defines.svh
`ifndef PIOC_DEFINES_SVH
`define PIOC_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PIOC_OFS_TRIM   8'h00
`define PIOC_OFS_CFG    8'h04
`define PIOC_OFS_CTRL   8'h08
`define PIOC_OFS_FEAT   8'h0c
`define PIOC_OFS_STAT   8'h10
`define PIOC_OFS_CORE   8'h14
`define PIOC_OFS_USB    8'h18
// ----------------------------------------
// field positions
// ----------------------------------------
`define PIOC_TRIM_SRC   7
`define PIOC_TRIM_MASK  8'h9f
`define PIOC_CFG_MODE   3:0
`define PIOC_CFG_PRE    6:4
`define PIOC_CFG_CDIV   9:8
`define PIOC_CFG_USBEN  12
`define PIOC_CFG_USBLS  13
`define PIOC_CFG_MASK   32'h0000_337f
`define PIOC_CTRL_SEL   1:0
`define PIOC_CTRL_IFS   6:4
`define PIOC_CTRL_MASK  32'h0000_0073
`define PIOC_FEAT_MASK  32'h0000_000f
// ----------------------------------------
// reset values
// ----------------------------------------
`define PIOC_RST_TRIM   8'h00
`define PIOC_RST_CFG    32'h0000_0000
`define PIOC_RST_CTRL   32'h0000_0000
`define PIOC_RST_FEAT   32'h0000_0000
// ----------------------------------------
// frequencies in khz and timing
// ----------------------------------------
`define PIOC_PLL_REF_KHZ  24'd4000
`define PIOC_PLL_MULT     24'd24
`define PIOC_FAST_KHZ     24'd8000
`define PIOC_MAX_OSC_KHZ  24'd48000
`define PIOC_LS_USB_KHZ   24'd6000
`define PIOC_FS_USB_KHZ   24'd48000
`define PIOC_LS_CORE_KHZ  24'd24000
`define PIOC_LS_USB_DIV   24'd4
`define PIOC_SETTLE_US    1000
`define PIOC_CLK_KHZ      20000
`define PIOC_SETTLE_CYC   (`PIOC_SETTLE_US * `PIOC_CLK_KHZ / 1000)
`endif

// File: rtl/pioc_pkg.sv
package pioc_pkg;
  typedef enum logic [3:0] {
    slow_crystal_mode               = 4'h0,
    slow_crystal_pll_mode           = 4'h1,
    fast_crystal_mode               = 4'h2,
    fast_crystal_pll_mode           = 4'h3,
    ext_clock_mode                  = 4'h4,
    ext_clock_gpio_mode             = 4'h5,
    ext_clock_pll_mode              = 4'h6,
    ext_clock_pll_gpio_mode         = 4'h7,
    internal_core_slow_crystal_usb  = 4'h8,
    internal_core_fast_crystal_usb  = 4'h9,
    internal_core_ext_clock_out_usb = 4'ha,
    internal_core_ext_clock_gpio_usb = 4'hb
  } pioc_mode_t;
  typedef enum logic [1:0] {
    osc2_crystal = 2'h0,
    osc2_quarter = 2'h1,
    osc2_gpio    = 2'h2
  } pioc_osc2_t;
  typedef logic [23:0] pioc_khz_t;
  typedef struct packed {
    pioc_khz_t pll_out;
    pioc_khz_t fast;
    pioc_khz_t internal;
    pioc_khz_t core;
    pioc_khz_t usb;
  } pioc_freq_t;
  typedef struct packed {
    logic pll;
    logic fast;
    logic slow;
    logic xtal_hs;
    logic xtal_lp;
  } pioc_en_t;
endpackage

// File: rtl/pioc_settle_timer.sv
`timescale 1ns/10ps
`default_nettype none
module pioc_settle_timer #(
  parameter int CYCLES = 20000
) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic start_i,
  output logic      done_o
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] count;
  // restart on every start so the latest change wins
  always_ff @(posedge clk_i) begin
    if (srst_i || start_i) begin
      count <= start_i ? W'(CYCLES) : '0;
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= !start_i && (count == W'(1));
    end
  end
endmodule
`default_nettype wire

// File: verif/pioc_clocking_props.sv
`timescale 1ns/10ps
`default_nettype none
module pioc_clocking_props
  import pioc_pkg::*;
#(
  parameter int        SETTLE_CYCLES = 20000,
  parameter pioc_khz_t TRIM_STEP_KHZ = 24'd40
) (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  // bus
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  input  wire logic        S_AXI_AWREADY_O,
  input  wire logic        S_AXI_WVALID_I,
  input  wire logic        S_AXI_WREADY_O,
  input  wire logic [1:0]  S_AXI_BRESP_O,
  input  wire logic        S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  input  wire logic        S_AXI_ARREADY_O,
  input  wire logic [31:0] S_AXI_RDATA_O,
  input  wire logic        S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  // clock network
  input  wire pioc_freq_t  FREQ_O,
  input  wire pioc_en_t    EN_O,
  input  wire logic [4:0]  TRIM_APPLIED_O
);
  logic [7:0]  rd_addr;
  int unsigned since_trim;
  pioc_khz_t   fast_exp;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  always_ff @(posedge CLK_I) begin
    if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      rd_addr <= S_AXI_ARADDR_I;
    end
  end
  // saturates so a long idle spell cannot wrap into a false failure
  always_ff @(posedge CLK_I) begin
    if (SRST_I || (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_AWADDR_I[7:2] == 6'h00)) begin
      since_trim <= 0;
    end else if (since_trim < 32'hffff) begin
      since_trim <= since_trim + 1;
    end
  end
  assign fast_exp = 24'd8000 + {{19{TRIM_APPLIED_O[4]}}, TRIM_APPLIED_O} * TRIM_STEP_KHZ;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_wr_taken;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  endsequence
  sequence s_rd_taken;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##2 S_AXI_BVALID_O)
    else $error("write response missing");
  a_read_answer: assert property (s_rd_taken |=> S_AXI_RVALID_O)
    else $error("read response missing");
  a_bresp_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
    S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write response dropped");
  a_rdata_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
    S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read data dropped");
  a_write_refuse: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write taken while response pending");
  a_read_refuse: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("read taken while data pending");
  a_trim_rsvd: assert property (S_AXI_RVALID_O && rd_addr[7:2] == 6'h00 |->
    S_AXI_RDATA_O[31:8] == 24'h0 && S_AXI_RDATA_O[6:5] == 2'h0) else $error("trim pad bits set");
  a_trim_settle: assert property ($changed(TRIM_APPLIED_O) |-> since_trim >= SETTLE_CYCLES)
    else $error("trim applied too early");
  a_trim_freq: assert property ($stable(TRIM_APPLIED_O) [*3] |-> FREQ_O.fast == fast_exp)
    else $error("fast frequency off trim");
  a_pll_fixed: assert property (EN_O.pll [*2] |-> FREQ_O.pll_out == 24'd96000)
    else $error("pll output not fixed");
  a_fast_enable: assert property ((FREQ_O.internal >= 24'd125 &&
    FREQ_O.internal <= 24'd8000) [*2] |-> EN_O.fast) else $error("fast oscillator off");
endmodule
bind pioc_clocking pioc_clocking_props #(
  .SETTLE_CYCLES(SETTLE_CYCLES),
  .TRIM_STEP_KHZ(TRIM_STEP_KHZ)
) u_props (.CLK_I, .SRST_I, .S_AXI_AWADDR_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O,
  .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I,
  .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RVALID_O,
  .S_AXI_RREADY_I, .FREQ_O, .EN_O, .TRIM_APPLIED_O);
`default_nettype wire

// File: verif/pioc_osc_src.sv
`timescale 1ns/10ps
`default_nettype none
module pioc_osc_src
  import pioc_pkg::*;
(
  // clock and request
  input  wire logic      clk_i,
  input  wire pioc_khz_t set_khz_i,
  // frequency seen on the oscillator pins
  output pioc_khz_t      osc_khz_o
);
  // the fast circuit cannot swing above its ceiling, whatever is asked
  always @(posedge clk_i) begin
    osc_khz_o <= (set_khz_i > 24'd48000) ? 24'd48000 : set_khz_i;
  end
endmodule
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "pioc_defines.svh"
module testbench
  import pioc_pkg::*;
;
  localparam int        SETTLE = 16;
  localparam pioc_khz_t STEP   = 24'd40;
  logic        clk = 1'b0, srst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  pioc_khz_t   osc, set_khz = 24'd4000;
  pioc_freq_t  freq;
  pioc_en_t    en;
  pioc_osc2_t  osc2;
  logic [4:0]  trim_app;
  int          n_fail = 0, n_checks = 0, seed = 93634;
  int          pdiv [8] = '{1, 2, 3, 4, 5, 6, 10, 12};
  int          cdiv [4] = '{2, 3, 4, 6};

  always #25 clk = ~clk;

  pioc_osc_src u_osc (.clk_i(clk), .set_khz_i(set_khz), .osc_khz_o(osc));

  pioc_clocking #(.SETTLE_CYCLES(SETTLE), .TRIM_STEP_KHZ(STEP)) DUT (
    .CLK_I(clk), .SRST_I(srst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .OSC_KHZ_I(osc), .FREQ_O(freq), .EN_O(en), .OSC2_FUNC_O(osc2), .TRIM_APPLIED_O(trim_app)
  );

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ready is looked at mid-cycle, where it equals what the next edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k, dly;
    logic ta, tw, tb;
    dly = $random(seed) & 3;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= (dly == 0);
    for (k = 0; k < 100; k++) begin
      @(negedge clk);
      ta = awvalid && awready; tw = wvalid && wready; tb = bready && bvalid; r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      bready <= (k + 1 >= dly) && !tb;
      if (tb) break;
    end
    chk(32'(k < 100), 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k, dly;
    logic ta, tr;
    dly = $random(seed) & 3;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= (dly == 0);
    for (k = 0; k < 100; k++) begin
      @(negedge clk);
      ta = arvalid && arready; tr = rready && rvalid; d = rdata; r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      rready <= (k + 1 >= dly) && !tr;
      if (tr) break;
    end
    chk(32'(k < 100), 32'h1);
  endtask

  // parks in a non-pll mode first so the source never moves under a running pll
  task automatic setup(input pioc_khz_t k, input logic [31:0] c);
    logic [1:0] r;
    wr(`PIOC_OFS_CFG, 32'h0, r);
    set_khz <= k;
    repeat (2) @(posedge clk);
    wr(`PIOC_OFS_CFG, c, r);
    repeat (3) @(negedge clk);
  endtask

  function automatic pioc_khz_t fexp(input logic [4:0] v);
    return 24'd8000 + {{19{v[4]}}, v} * STEP;
  endfunction
  function automatic pioc_khz_t iexp(input int n, input logic src, input pioc_khz_t f);
    if (n == 7) return f;
    if (n != 0) return f >> (7 - n);
    return src ? f >> 8 : 24'd31;
  endfunction
  function automatic logic [1:0] o2exp(input int m);
    if (m == 4 || m == 6 || m == 10) return 2'h1;
    if (m == 5 || m == 7 || m == 11) return 2'h2;
    return 2'h0;
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [4:0]  tv, pv;
    int          m, p, c;
    pioc_khz_t   k;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(`PIOC_OFS_TRIM, d, r);
    chk(d, 32'h0);
    rd(8'h40, d, r);
    chk(32'(r), 32'h3);
    wr(8'h40, 32'hffff_ffff, r);
    chk(32'(r), 32'h3);
    wr(`PIOC_OFS_TRIM, 32'h0000_0060, r);
    rd(`PIOC_OFS_TRIM, d, r);
    chk(d, 32'h0);
    pv = 5'h00;
    for (int t = 0; t < 7; t++) begin
      tv = (t == 0) ? 5'h10 : (t == 1) ? 5'h00 : (t == 6) ? 5'h0f : 5'($random(seed));
      wr(`PIOC_OFS_TRIM, {27'h0, tv}, r);
      @(negedge clk);
      chk(32'(trim_app), 32'(pv));
      repeat (SETTLE + 4) @(negedge clk);
      chk(32'(trim_app), 32'(tv));
      chk(32'(freq.fast), 32'(fexp(tv)));
      pv = tv;
    end
    for (int i = 0; i < 9; i++) begin
      p = (i == 8) ? 0 : i;
      wr(`PIOC_OFS_TRIM, {24'h0, i == 8, 2'b0, tv}, r);
      wr(`PIOC_OFS_CTRL, {25'h0, 3'(p), 2'b0, 2'b10}, r);
      repeat (3) @(negedge clk);
      chk(32'(freq.internal), 32'(iexp(p, i == 8, fexp(tv))));
      chk(32'(freq.core), 32'(iexp(p, i == 8, fexp(tv))));
      chk(32'(en.fast), 32'(p != 0 || i == 8));
      if (i == 0) chk(32'(en.slow), 32'h1);
    end
    wr(`PIOC_OFS_CTRL, 32'h0000_0070, r);
    for (int i = 0; i < 5; i++) begin
      wr(`PIOC_OFS_FEAT, 32'(i < 4) << i, r);
      repeat (3) @(negedge clk);
      chk(32'(en.slow), 32'(i < 4));
    end
    wr(`PIOC_OFS_CTRL, 32'h0, r);
    wr(`PIOC_OFS_TRIM, {27'h0, tv}, r);
    for (int i = 0; i < 20; i++) begin
      m = (i < 12) ? i : (i[0] ? 3 : 6);
      p = (i < 12) ? ($random(seed) & 7) : i - 12;
      c = $random(seed) & 3;
      k = (m == 1) ? 24'd4000 : (m inside {3, 6, 7}) ? 24'(4000 * pdiv[p])
          : 24'(12000 * (1 + ($random(seed) & 3)));
      setup(k, 32'(m) | 32'(p) << 4 | 32'(c) << 8 | 32'h1000);
      chk(32'(en.pll), 32'(m inside {1, 3, 6, 7}));
      chk(32'(osc2), 32'(o2exp(m)));
      if (m inside {1, 3, 6, 7}) begin
        chk(32'(freq.pll_out), 32'd96000);
        chk(32'(freq.core), 96000 / cdiv[c]);
        chk(32'(freq.usb), 32'd48000);
      end else if (m < 8) begin
        chk(32'(freq.core), k / (c + 1));
      end else begin
        chk(32'(freq.core), 32'd31);
      end
      chk(32'(en.slow), 32'(m >= 8));
      chk(32'(en.xtal_hs), 32'(m inside {2, 3, 6, 7, 9}));
      chk(32'(en.xtal_lp), 32'(m inside {0, 1, 8}));
    end
    for (int i = 0; i < 3; i++) begin
      setup(i == 2 ? 24'd24000 : 24'd20000,
            32'h3040 | (i == 2 ? 32'h2 : 32'h3) | (i == 0 ? 32'h200 : 32'h0));
      chk(32'(freq.usb), i == 1 ? 32'd12000 : 32'd6000);
      rd(`PIOC_OFS_STAT, d, r);
      chk(32'(d[5]), 32'(i == 1));
    end
    results();
  end
endmodule
`default_nettype wire
